// file: inc/pps_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package pps_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_PMCSR  = 8'h00;
    localparam logic [7:0] ADDR_PMTCTL = 8'h04;
    localparam logic [7:0] ADDR_BUSCFG = 8'h08;
    localparam logic [7:0] ADDR_PHYCTL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // field positions
    localparam int PMCSR_EVT_EN   = 8;
    localparam int PMCSR_PME_STS  = 15;
    localparam int PMT_ED_EN      = 1;
    localparam int PMT_WOL_EN     = 2;
    localparam int PMT_WUPS_LO    = 4;
    localparam int PMT_PHY_HARD   = 10;
    localparam int BUS_SW_RESET   = 0;
    localparam int BUS_INIT_DONE  = 1;
    localparam int PHY_SOFT_RST   = 15;
    // power state encodings
    localparam logic [1:0] PS_D0  = 2'h0;
    localparam logic [1:0] PS_D3  = 2'h3;
    // power-on reset time
    localparam int POR_TIME_MS    = 21;
    localparam int CLK_KHZ        = 100000;
    localparam int POR_CYCLES     = POR_TIME_MS * CLK_KHZ;
    typedef enum logic [2:0] {ST_POR, ST_D0U, ST_D0A, ST_D3HOT, ST_D3COLD} pps_state_t;
endpackage : pps_pkg

// file: rtl/pps_top.sv
`timescale 1ns/10ps
`default_nettype none
module pps_top #(
    parameter int unsigned PorCycles = pps_pkg::POR_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        mainPowerGood,
    input  wire logic        auxPowerDetect,
    input  wire logic        hostBusResetN,
    input  wire logic        macWakeEvent,
    input  wire logic        phyLinkEvent,
    output var  logic        wakeRequestN,
    output var  logic        powerOnReset,
    output var  logic        d3ExitReset,
    output var  logic        macReset,
    output var  logic        dmaReset,
    output var  logic        csrReset,
    output var  logic        pciCfgReset,
    output var  logic        pmeLogicReset,
    output var  logic        eepromLoad,
    output var  logic        phyReset,
    output var  logic        phySoftReset,
    output var  logic        phyPowerDown,
    output var  logic        pllEnable,
    output var  logic        ethEnable,
    output var  logic        memIoRespond,
    output var  logic        cfgRespond
);

//////////////////////////////////////////////////////////////////////////////
// pin synchronisers
//////////////////////////////////////////////////////////////////////////////
    logic [2:0] pinMeta_q;
    logic [2:0] pinSync_q;
    logic       hostRstPrev_q;
    logic       mainGoodPrev_q;
    wire  [2:0] pinRaw = {hostBusResetN, auxPowerDetect, mainPowerGood};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk)
            begin
                pinMeta_q[gi] <= rst ? 1'b0 : pinRaw[gi];
                pinSync_q[gi] <= rst ? 1'b0 : pinMeta_q[gi];
            end
        end
    endgenerate

    wire mainGood = pinSync_q[0];
    wire auxDet   = pinSync_q[1];
    wire hostRstN = pinSync_q[2];
    wire hostRise = hostRstN & ~hostRstPrev_q;
    wire mainRise = mainGood & ~mainGoodPrev_q;

//////////////////////////////////////////////////////////////////////////////
// state and context
//////////////////////////////////////////////////////////////////////////////
    // all of this sits on the free-running clock, never the PLL output
    pps_pkg::pps_state_t state_q, state_d;
    logic [21:0] porCnt_q;
    logic        auxStrap_q;
    logic [1:0]  powerStateField_q;
    logic        pmEventEnable_q;
    logic        pmeStatus_q;
    logic        wolEn_q;
    logic        edEn_q;
    logic [1:0]  wakeStatus_q;
    logic        phyRstOnEntry_q;
    logic        phyPowerDown_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        wakeRequestN_q;
    logic        powerOnReset_q;
    logic        d3ExitReset_q;
    logic        macReset_q;
    logic        dmaReset_q;
    logic        csrReset_q;
    logic        pciCfgReset_q;
    logic        pmeLogicReset_q;
    logic        eepromLoad_q;
    logic        phyReset_q;
    logic        phySoftReset_q;
    logic        pllEnable_q;
    logic        ethEnable_q;
    logic        memIoRespond_q;
    logic        cfgRespond_q;

    wire inD0   = (state_q == pps_pkg::ST_D0U) | (state_q == pps_pkg::ST_D0A);
    wire inHot  = (state_q == pps_pkg::ST_D3HOT);
    wire inCold = (state_q == pps_pkg::ST_D3COLD);
    wire porAct = (state_q == pps_pkg::ST_POR);
    wire porEnd = porAct & (porCnt_q == 22'(PorCycles - 1));

//////////////////////////////////////////////////////////////////////////////
// apb decode
//////////////////////////////////////////////////////////////////////////////
    // one wait state so read data and error come straight from flops
    wire accStart  = psel & penable & ~pready_q;
    wire accDone   = psel & penable & pready_q;
    wire selPmcsr  = (paddr == pps_pkg::ADDR_PMCSR);
    wire selPmt    = (paddr == pps_pkg::ADDR_PMTCTL);
    wire selBus    = (paddr == pps_pkg::ADDR_BUSCFG);
    wire selPhy    = (paddr == pps_pkg::ADDR_PHYCTL);
    wire selStat   = (paddr == pps_pkg::ADDR_STATUS);
    wire mapped    = selPmcsr | selPmt | selBus | selPhy | selStat;
    // isolated from the bus in cold sleep and while power-on reset runs
    wire busBlock  = inCold | porAct;
    wire wrOk      = accDone & pwrite & mapped & ~busBlock;
    wire wrPmcsr   = wrOk & selPmcsr;
    wire wrPmt     = wrOk & selPmt;
    wire wrBus     = wrOk & selBus;
    wire wrPhy     = wrOk & selPhy;
    wire [1:0] psReq = pwdata[1:0];

//////////////////////////////////////////////////////////////////////////////
// transition events
//////////////////////////////////////////////////////////////////////////////
    wire goHot      = inD0 & wrPmcsr & (psReq == pps_pkg::PS_D3);
    wire d3Exit     = inHot & wrPmcsr & (psReq == pps_pkg::PS_D0);
    wire hotToCold  = inHot & ~mainGood & auxDet;
    wire d0ToCold   = inD0 & ~mainGood & auxDet;
    wire coldExit   = inCold & mainRise;
    wire hostRstD0  = inD0 & ~hostRstN;
    wire hostRstHot = inHot & hostRise & ~d3Exit;
    wire hostAny    = hostRstD0 | hostRstHot;
    wire swRst      = wrBus & pwdata[pps_pkg::BUS_SW_RESET];
    wire phyHard    = wrPmt & pwdata[pps_pkg::PMT_PHY_HARD];
    wire phySoft    = wrPhy & pwdata[pps_pkg::PHY_SOFT_RST];
    wire sleepPd    = (goHot | d0ToCold) & ~pmEventEnable_q;
    // cold wake support is strapped by aux detect at power-on
    wire pmeClrHost = hostAny & ~auxStrap_q;
    wire pmeClr     = powerOnReset_q | pmeClrHost;
    wire ctxClr     = hostAny | d3Exit | coldExit;
    wire wakeAllow  = inHot | (inCold & auxDet) | (state_q == pps_pkg::ST_D0A);
    wire wakeHit    = |(wakeStatus_q & {wolEn_q, edEn_q});

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pps_pkg::ST_POR:
                if (porEnd)
                    state_d = auxStrap_q ? pps_pkg::ST_D3COLD : pps_pkg::ST_D0U;
            pps_pkg::ST_D0U, pps_pkg::ST_D0A:
                if (hostRstD0)
                    state_d = pps_pkg::ST_D0U;
                else if (d0ToCold)
                    state_d = pps_pkg::ST_D3COLD;
                else if (goHot)
                    state_d = pps_pkg::ST_D3HOT;
                else if (wrBus & pwdata[pps_pkg::BUS_INIT_DONE])
                    state_d = pps_pkg::ST_D0A;
            pps_pkg::ST_D3HOT:
                if (hotToCold)
                    state_d = pps_pkg::ST_D3COLD;
                else if (d3Exit | hostRstHot)
                    state_d = pps_pkg::ST_D0U;
            pps_pkg::ST_D3COLD:
                if (coldExit)
                    state_d = pps_pkg::ST_D0U;
            default:
                state_d = pps_pkg::ST_POR;
        endcase
    end

//////////////////////////////////////////////////////////////////////////////
// reset map
//////////////////////////////////////////////////////////////////////////////
    wire blockRst   = powerOnReset_q | hostAny | d3Exit | coldExit;
    wire phyRstD    = powerOnReset_q | hostAny | coldExit | phyHard
                    | (d3Exit & phyRstOnEntry_q) | sleepPd;

    wire [31:0] rdPmcsr = {16'h0, pmeStatus_q, 6'h0, pmEventEnable_q, 6'h0, powerStateField_q};
    wire [31:0] rdPmt   = {26'h0, wakeStatus_q, 1'b0, wolEn_q, edEn_q, 1'b0};
    wire [31:0] rdStat  = {16'h0, 5'h0, 3'(state_q), 2'h0, auxStrap_q, phyPowerDown_q,
                           phyRstOnEntry_q, pllEnable_q, ethEnable_q, memIoRespond_q};
    wire [31:0] rdMux   = selPmcsr ? rdPmcsr :
                          selPmt   ? rdPmt   :
                          selStat  ? rdStat  : 32'h0;

//////////////////////////////////////////////////////////////////////////////
// sequencing flops
//////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q        <= pps_pkg::ST_POR;
            porCnt_q       <= 22'h0;
            auxStrap_q     <= 1'b0;
            hostRstPrev_q  <= 1'b0;
            mainGoodPrev_q <= 1'b0;
        end
        else
        begin
            state_q        <= state_d;
            porCnt_q       <= porAct ? porCnt_q + 22'h1 : 22'h0;
            hostRstPrev_q  <= hostRstN;
            mainGoodPrev_q <= mainGood;
            if (porAct)
                auxStrap_q <= auxDet;
        end
    end

    // power state field and PHY mode
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            powerStateField_q <= pps_pkg::PS_D0;
            phyPowerDown_q    <= 1'b0;
            phyRstOnEntry_q   <= 1'b0;
        end
        else if (porEnd)
        begin
            powerStateField_q <= auxStrap_q ? pps_pkg::PS_D3 : pps_pkg::PS_D0;
            phyPowerDown_q    <= auxStrap_q;
            phyRstOnEntry_q   <= 1'b0;
        end
        else
        begin
            if (goHot | hotToCold)
                powerStateField_q <= pps_pkg::PS_D3;
            else if (ctxClr)
                powerStateField_q <= pps_pkg::PS_D0;
            if (sleepPd)
                phyPowerDown_q <= 1'b1;
            else if (coldExit | (d3Exit & phyRstOnEntry_q) | hostAny)
                phyPowerDown_q <= 1'b0;
            if (goHot)
                phyRstOnEntry_q <= ~pmEventEnable_q;
            else if (ctxClr)
                phyRstOnEntry_q <= 1'b0;
        end
    end

    // PME context survives cold exit and, when strapped, host bus reset
    always_ff @(posedge sys_clk)
    begin
        if (rst | pmeClr)
        begin
            pmEventEnable_q <= 1'b0;
            pmeStatus_q     <= 1'b0;
        end
        else
        begin
            if (wrPmcsr)
                pmEventEnable_q <= pwdata[pps_pkg::PMCSR_EVT_EN];
            // set wins over a write-one clear in the same cycle
            if (wakeAllow & wakeHit)
                pmeStatus_q <= 1'b1;
            else if (wrPmcsr & pwdata[pps_pkg::PMCSR_PME_STS])
                pmeStatus_q <= 1'b0;
        end
    end

    // wake enables are protected from software reset
    always_ff @(posedge sys_clk)
    begin
        if (rst | blockRst)
        begin
            wolEn_q      <= 1'b0;
            edEn_q       <= 1'b0;
            wakeStatus_q <= 2'h0;
        end
        else
        begin
            if (wrPmt)
            begin
                wolEn_q <= pwdata[pps_pkg::PMT_WOL_EN];
                edEn_q  <= pwdata[pps_pkg::PMT_ED_EN];
            end
            wakeStatus_q <= (swRst ? 2'h0 : wakeStatus_q)
                          & ~({2{wrPmt}} & pwdata[pps_pkg::PMT_WUPS_LO +: 2])
                          | {macWakeEvent, phyLinkEvent};
        end
    end

//////////////////////////////////////////////////////////////////////////////
// outputs
//////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prdata_q        <= 32'h0;
            pready_q        <= 1'b0;
            pslverr_q       <= 1'b0;
            wakeRequestN_q  <= 1'b1;
            powerOnReset_q  <= 1'b1;
            d3ExitReset_q   <= 1'b0;
            macReset_q      <= 1'b1;
            dmaReset_q      <= 1'b1;
            csrReset_q      <= 1'b1;
            pciCfgReset_q   <= 1'b1;
            pmeLogicReset_q <= 1'b1;
            eepromLoad_q    <= 1'b0;
            phyReset_q      <= 1'b1;
            phySoftReset_q  <= 1'b0;
            pllEnable_q     <= 1'b0;
            ethEnable_q     <= 1'b0;
            memIoRespond_q  <= 1'b0;
            cfgRespond_q    <= 1'b0;
        end
        else
        begin
            prdata_q        <= accStart ? rdMux : 32'h0;
            pready_q        <= accStart;
            pslverr_q       <= accStart & (~mapped | busBlock);
            wakeRequestN_q  <= ~(pmeStatus_q & pmEventEnable_q);
            powerOnReset_q  <= porAct & ~porEnd;
            d3ExitReset_q   <= d3Exit;
            macReset_q      <= blockRst | swRst;
            dmaReset_q      <= blockRst | swRst;
            csrReset_q      <= blockRst | swRst;
            pciCfgReset_q   <= blockRst;
            pmeLogicReset_q <= pmeClr;
            eepromLoad_q    <= (porEnd & ~auxStrap_q) | hostAny | coldExit;
            phyReset_q      <= phyRstD;
            phySoftReset_q  <= phySoft;
            pllEnable_q     <= inD0 & ~goHot & ~d0ToCold;
            ethEnable_q     <= (state_d == pps_pkg::ST_D0A);
            memIoRespond_q  <= (state_d == pps_pkg::ST_D0U)
                             | (state_d == pps_pkg::ST_D0A);
            cfgRespond_q    <= (state_d != pps_pkg::ST_D3COLD)
                             & (state_d != pps_pkg::ST_POR);
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign wakeRequestN  = wakeRequestN_q;
    assign powerOnReset  = powerOnReset_q;
    assign d3ExitReset   = d3ExitReset_q;
    assign macReset      = macReset_q;
    assign dmaReset      = dmaReset_q;
    assign csrReset      = csrReset_q;
    assign pciCfgReset   = pciCfgReset_q;
    assign pmeLogicReset = pmeLogicReset_q;
    assign eepromLoad    = eepromLoad_q;
    assign phyReset      = phyReset_q;
    assign phySoftReset  = phySoftReset_q;
    assign phyPowerDown  = phyPowerDown_q;
    assign pllEnable     = pllEnable_q;
    assign ethEnable     = ethEnable_q;
    assign memIoRespond  = memIoRespond_q;
    assign cfgRespond    = cfgRespond_q;

endmodule : pps_top
`default_nettype wire

// file: tb/pps_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pps_checker #(
    parameter int unsigned PorCycles = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hostBusResetN,
    input wire logic powerOnReset,
    input wire logic d3ExitReset,
    input wire logic macReset,
    input wire logic dmaReset,
    input wire logic csrReset,
    input wire logic pciCfgReset,
    input wire logic eepromLoad,
    input wire logic ethEnable,
    input wire logic memIoRespond,
    input wire logic cfgRespond
);
    // counts power-on cycles; a plain repetition could not span PorCycles
    logic [31:0] porCnt_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            porCnt_q <= 32'h0;
        else if (powerOnReset)
            porCnt_q <= porCnt_q + 32'h1;
    end
    ////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_PREADY_WAIT:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    AST_PREADY_ONE:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_ETH_D0:
    assert property (ethEnable |-> memIoRespond && cfgRespond) else $error("eth outside d0");
    AST_MEMIO_CFG:
    assert property (memIoRespond |-> cfgRespond) else $error("memory access without config");
    AST_COLD_REFUSE:
    assert property (pready && !cfgRespond |-> pslverr) else $error("isolated bus answered");
    AST_D3EXIT_PULSE:
    assert property ($rose(d3ExitReset) |=> !d3ExitReset) else $error("sleep exit not a pulse");
    AST_D3EXIT_MAP:
    assert property (d3ExitReset |-> macReset && dmaReset && csrReset && pciCfgReset
        && !eepromLoad) else $error("sleep exit reset map wrong");
    AST_HOST_HOLD:
    assert property ((!hostBusResetN && memIoRespond) ##1 !hostBusResetN [*5] |-> macReset)
        else $error("mac not held in reset");
    AST_POR_TIME:
    assert property ($fell(powerOnReset) |-> porCnt_q >= PorCycles && porCnt_q <= PorCycles + 3)
        else $error("power-on reset length wrong");
endmodule : pps_checker
bind pps_top pps_checker #(.PorCycles(PorCycles)) pps_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .hostBusResetN(hostBusResetN), .powerOnReset(powerOnReset),
    .d3ExitReset(d3ExitReset), .macReset(macReset), .dmaReset(dmaReset), .csrReset(csrReset),
    .pciCfgReset(pciCfgReset), .eepromLoad(eepromLoad), .ethEnable(ethEnable),
    .memIoRespond(memIoRespond), .cfgRespond(cfgRespond));
`default_nettype wire

// file: tb/pps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pps_host_model (
    input  wire logic sys_clk,
    input  wire logic mainOn,
    input  wire logic auxOn,
    input  wire logic busRstReq,
    output var  logic mainPowerGood,
    output var  logic auxPowerDetect,
    output var  logic hostBusResetN
);
    logic [3:0] relCnt_q = 4'h0;
    always_ff @(posedge sys_clk)
    begin
        if (!mainOn)
            relCnt_q <= 4'h0;
        else if (relCnt_q != 4'hf)
            relCnt_q <= relCnt_q + 4'h1;
    end
    // host keeps bus reset low until main rails have settled
    assign hostBusResetN = mainOn && (relCnt_q == 4'hf) && !busRstReq;
    // aux rail independent, so main may drop under it
    assign mainPowerGood = mainOn;
    assign auxPowerDetect = auxOn;
endmodule : pps_host_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic wr; logic [7:0] addr; logic [31:0] data; logic [31:0] rd;
        logic err; logic [8:0] seen; logic [4:0] lv;
    } pps_row_t;
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, errv, clrSeen = 1'b0, macWakeEvent = 1'b0;
    logic        phyLinkEvent = 1'b0;
    logic        mainOn = 1'b1, auxOn = 1'b0, busRstReq = 1'b0;
    logic        mainPowerGood, auxPowerDetect, hostBusResetN, wakeRequestN, powerOnReset;
    logic        d3ExitReset, macReset, dmaReset, csrReset, pciCfgReset, pmeLogicReset;
    logic        eepromLoad, phyReset, phySoftReset, phyPowerDown, pllEnable, ethEnable;
    logic        memIoRespond, cfgRespond;
    logic [8:0]  seen_q = 9'h0;
    int          failures = 0, cmp_count = 0;
    pps_row_t    rows [12];
    wire  [8:0]  pulses = {eepromLoad, d3ExitReset, phySoftReset, phyReset, pmeLogicReset,
                           pciCfgReset, csrReset, dmaReset, macReset};
    wire  [4:0]  levels = {memIoRespond, cfgRespond, ethEnable, pllEnable, phyPowerDown};
    always #5 sys_clk = ~sys_clk;
    // some pulses last one cycle, so latch every one seen since the last clear
    always @(posedge sys_clk) seen_q <= clrSeen ? 9'h0 : (seen_q | pulses);
    pps_host_model pps_host_model_inst (.sys_clk(sys_clk), .mainOn(mainOn), .auxOn(auxOn),
        .busRstReq(busRstReq), .mainPowerGood(mainPowerGood), .auxPowerDetect(auxPowerDetect),
        .hostBusResetN(hostBusResetN));
    pps_top #(.PorCycles(20)) pps_top_inst (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mainPowerGood(mainPowerGood),
        .auxPowerDetect(auxPowerDetect), .hostBusResetN(hostBusResetN),
        .macWakeEvent(macWakeEvent), .phyLinkEvent(phyLinkEvent), .wakeRequestN(wakeRequestN),
        .powerOnReset(powerOnReset), .d3ExitReset(d3ExitReset), .macReset(macReset),
        .dmaReset(dmaReset), .csrReset(csrReset), .pciCfgReset(pciCfgReset),
        .pmeLogicReset(pmeLogicReset), .eepromLoad(eepromLoad), .phyReset(phyReset),
        .phySoftReset(phySoftReset), .phyPowerDown(phyPowerDown), .pllEnable(pllEnable),
        .ethEnable(ethEnable), .memIoRespond(memIoRespond), .cfgRespond(cfgRespond));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        clrSeen <= 1'b1;
        @(posedge sys_clk);
        penable <= 1'b1;
        clrSeen <= 1'b0;
        // no cycle count assumed; only the watchdog ends a hung wait
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wake(input logic [1:0] ev);
        {macWakeEvent, phyLinkEvent} <= ev;
        @(posedge sys_clk);
        {macWakeEvent, phyLinkEvent} <= 2'b00;
        repeat (8) @(posedge sys_clk);
        chk({31'h0, wakeRequestN}, 32'h0);
    endtask : wake
    task automatic complete_run();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial
    begin
        #100000;
        failures++;
        complete_run();
    end
    initial
    begin
        rows[0] = '{1'b1, pps_pkg::ADDR_BUSCFG, 32'h1, 32'h0, 1'b0, 9'h007, 5'h1a};
        rows[1] = '{1'b1, pps_pkg::ADDR_PMTCTL, 32'h400, 32'h0, 1'b0, 9'h020, 5'h1a};
        rows[2] = '{1'b1, pps_pkg::ADDR_PHYCTL, 32'h8000, 32'h0, 1'b0, 9'h040, 5'h1a};
        rows[3] = '{1'b1, pps_pkg::ADDR_BUSCFG, 32'h2, 32'h0, 1'b0, 9'h000, 5'h1e};
        rows[4] = '{1'b0, pps_pkg::ADDR_STATUS, 32'h0, 32'h207, 1'b0, 9'h000, 5'h1e};
        rows[5] = '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1, 9'h000, 5'h1e};
        rows[6] = '{1'b1, pps_pkg::ADDR_PMCSR, 32'h3, 32'h0, 1'b0, 9'h020, 5'h09};
        rows[7] = '{1'b0, pps_pkg::ADDR_PMCSR, 32'h0, 32'h3, 1'b0, 9'h000, 5'h09};
        rows[8] = '{1'b1, pps_pkg::ADDR_PMCSR, 32'h0, 32'h0, 1'b0, 9'h0af, 5'h1a};
        rows[9] = '{1'b1, pps_pkg::ADDR_PMCSR, 32'h100, 32'h0, 1'b0, 9'h000, 5'h1a};
        rows[10] = '{1'b1, pps_pkg::ADDR_PMCSR, 32'h103, 32'h0, 1'b0, 9'h000, 5'h08};
        rows[11] = '{1'b1, pps_pkg::ADDR_PMTCTL, 32'h6, 32'h0, 1'b0, 9'h000, 5'h08};
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 100 && powerOnReset !== 1'b0; k++)
            @(posedge sys_clk);
        // pll enable follows the state register one cycle later
        @(posedge sys_clk);
        chk({27'h0, levels}, 32'h1a);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            repeat (6) @(posedge sys_clk);
            if (!rows[i].wr)
                chk(rdv, rows[i].rd);
            chk({31'h0, errv}, {31'h0, rows[i].err});
            chk({23'h0, seen_q}, {23'h0, rows[i].seen});
            chk({27'h0, levels}, {27'h0, rows[i].lv});
        end
        wake(2'b01);
        apb(1'b1, pps_pkg::ADDR_PMTCTL, 32'h34);
        apb(1'b1, pps_pkg::ADDR_PMCSR, 32'h8103);
        repeat (4) @(posedge sys_clk);
        chk({31'h0, wakeRequestN}, 32'h1);
        auxOn <= 1'b1;
        @(posedge sys_clk);
        mainOn <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk({28'h0, levels[4:1]}, 32'h0);
        apb(1'b0, pps_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, errv}, 32'h1);
        wake(2'b10);
        mainOn <= 1'b1;
        clrSeen <= 1'b1;
        @(posedge sys_clk);
        clrSeen <= 1'b0;
        repeat (30) @(posedge sys_clk);
        chk({23'h0, seen_q & 9'h001}, 32'h1);
        chk({31'h0, phyPowerDown}, 32'h0);
        busRstReq <= 1'b1;
        clrSeen <= 1'b1;
        @(posedge sys_clk);
        clrSeen <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({31'h0, macReset}, 32'h1);
        busRstReq <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({23'h0, seen_q & 9'h111}, 32'h111);
        // bus reset in hot sleep acts only on its release
        apb(1'b1, pps_pkg::ADDR_PMCSR, 32'h3);
        busRstReq <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({27'h0, levels}, 32'h09);
        busRstReq <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({27'h0, levels}, 32'h1a);
        // second power-on with aux present lands in cold sleep
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (30) @(posedge sys_clk);
        chk({26'h0, powerOnReset, levels}, 32'h01);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
